// ==== gst_pkg.sv ====
/*
 * constants, field layouts and types of the gated sixteen-bit timer.
 * assumes a 20 MHz system clock and a byte-wide register port.
 */
package gst_pkg;

	localparam logic [2:0] OFF_COUNT_LOW  = 3'h0;
	localparam logic [2:0] OFF_COUNT_HIGH = 3'h1;
	localparam logic [2:0] OFF_TIMER_CTL  = 3'h2;
	localparam logic [2:0] OFF_GATE_CTL   = 3'h3;
	localparam logic [2:0] OFF_FLAGS      = 3'h4;
	localparam logic [2:0] OFF_IRQ_CTL    = 3'h5;

	// field positions of the flag and interrupt control registers
	localparam int BIT_OVF_FLAG  = 0;
	localparam int BIT_GATE_FLAG = 7;
	localparam int BIT_OVF_IE    = 0;
	localparam int BIT_GATE_IE   = 5;
	localparam int BIT_PERIPH_IE = 6;
	localparam int BIT_GLOBAL_IE = 7;

	localparam logic [7:0]  RESET_BYTE   = 8'h00;
	localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
	localparam logic [7:0]  T0_WRAP_FROM = 8'hFF;
	localparam logic [7:0]  T0_WRAP_TO   = 8'h00;
	localparam logic [15:0] ISR_VECTOR   = 16'h0004;

	// timing: temperature oscillator period in system clocks, rounded down
	localparam int SYS_CLK_HZ      = 20000000;
	localparam int TEMP_OSC_HZ     = 16000;
	localparam int TEMP_OSC_CYCLES = SYS_CLK_HZ / TEMP_OSC_HZ;
	localparam int INSTR_DIV       = 4;

	typedef enum logic [1:0] {
		GST_CS_INSTR = 2'h0,
		GST_CS_SYS   = 2'h1,
		GST_CS_EXT   = 2'h2,
		GST_CS_TEMP  = 2'h3
	} gst_clk_src_t;

	typedef enum logic [1:0] {
		GST_GS_PIN  = 2'h0,
		GST_GS_T0   = 2'h1,
		GST_GS_CMP1 = 2'h2,
		GST_GS_CMP2 = 2'h3
	} gst_gate_src_t;

	// gray along idle -> wait -> run
	typedef enum logic [1:0] {
		GST_SP_IDLE = 2'h0,
		GST_SP_WAIT = 2'h1,
		GST_SP_RUN  = 2'h3
	} gst_sp_state_t;

	typedef struct packed {
		gst_clk_src_t clock_source_select;
		logic [1:0]   prescale_select;
		logic         reserved;
		logic         sync_disable;
		logic         unused;
		logic         timer_on;
	} gst_timer_control_t;

	typedef struct packed {
		logic          gate_enable;
		logic          gate_polarity;
		logic          toggle_mode_enable;
		logic          single_pulse_enable;
		logic          acquisition_go;
		logic          gate_value;
		gst_gate_src_t gate_source_select;
	} gst_gate_control_t;

endpackage

// ==== gst_sync.sv ====
/*
 * two-stage synchroniser with rising-edge detect.
 * assumes one system clock; the raw input may change at any time.
 */
module gst_sync (
	input  wire logic sys_clk_i,
	input  wire logic reset_n_i,
	input  wire logic raw_i,
	output logic      level_o,
	output logic      rise_o
);
	logic meta;
	logic stable;
	logic stable_prev;

	// the first stage feeds only the second
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			meta        <= 1'b0;
			stable      <= 1'b0;
			stable_prev <= 1'b0;
		end
		else
		begin
			meta        <= raw_i;
			stable      <= meta;
			stable_prev <= stable;
		end
	end

	assign level_o = stable;
	assign rise_o  = stable & ~stable_prev;
endmodule

// ==== gst_prescaler.sv ====
/*
 * prescale counter passing every 1st, 2nd, 4th or 8th input tick.
 * assumes ticks are one-cycle enables of the system clock.
 */
module gst_prescaler #(
	parameter int WIDTH = 3
) (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       clear_i,
	input  wire logic       tick_i,
	input  wire logic [1:0] select_i,
	output logic            tick_o
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] mask;

	// low bits that must all be one before a tick passes
	assign mask   = WIDTH'((1 << select_i) - 1);
	assign tick_o = tick_i && ((count & mask) == mask);

	// software never sees this counter, only clears it
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
			count <= '0;
		else if (clear_i)
			count <= '0;
		else if (tick_i)
			count <= count + WIDTH'(1);
	end
endmodule

// ==== gst_timer.sv ====
/*
 * gated sixteen-bit timer: clock selection, prescaler, gate unit,
 * flags and byte register port.
 * assumes timer0 count and sleep are synchronous to sys_clk_i; the cpu owns the
 * interrupt vector and sleep state.
 */
// Design decisions made here: the register offsets and the strobed register port.
module gst_timer (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  wr_data_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        external_count_pin_i,
	input  wire logic        gate_input_i,
	input  wire logic        comparator_one_out_i,
	input  wire logic        comparator_two_out_i,
	input  wire logic [7:0]  eight_bit_timer_count_i,
	input  wire logic        sleep_i,
	output logic [7:0]       rd_data_o,
	output logic [15:0]      count_o,
	output logic             irq_o,
	output logic             wake_o
);
	gst_pkg::gst_timer_control_t tcon;
	gst_pkg::gst_gate_control_t  gcon;
	gst_pkg::gst_sp_state_t      sp_state;
	gst_pkg::gst_sp_state_t      next_sp_state;

	logic [15:0] count;
	logic [15:0] next_count;
	logic [7:0]  irq_ctl;
	logic        ovf_flag;
	logic        gate_flag;

	// register port decode
	wire wr_low   = wr_i && (addr_i == gst_pkg::OFF_COUNT_LOW);
	wire wr_high  = wr_i && (addr_i == gst_pkg::OFF_COUNT_HIGH);
	wire wr_tcon  = wr_i && (addr_i == gst_pkg::OFF_TIMER_CTL);
	wire wr_gcon  = wr_i && (addr_i == gst_pkg::OFF_GATE_CTL);
	wire wr_flags = wr_i && (addr_i == gst_pkg::OFF_FLAGS);
	wire wr_irq   = wr_i && (addr_i == gst_pkg::OFF_IRQ_CTL);
	wire wr_count = wr_low | wr_high;

	wire timer_on = tcon.timer_on;
	wire ext_sel  = (tcon.clock_source_select == gst_pkg::GST_CS_EXT);
	wire async_ext = ext_sel && tcon.sync_disable;

	// synchronisers: 0 external clock, 1 gate pin, 2/3 comparators
	logic [3:0] raw_in;
	logic [3:0] sync_lvl;
	logic [3:0] sync_rise;

	assign raw_in = {comparator_two_out_i, comparator_one_out_i,
		gate_input_i, external_count_pin_i};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_sync
			gst_sync u_sync (
				.sys_clk_i (sys_clk_i),
				.reset_n_i (reset_n_i),
				.raw_i     (raw_in[gi]),
				.level_o   (sync_lvl[gi]),
				.rise_o    (sync_rise[gi])
			);
		end
	endgenerate

	// unsynchronised path: a single sample, no resynchronising stages
	logic ext_raw_q;
	logic ext_raw_prev;

	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			ext_raw_q    <= 1'b0;
			ext_raw_prev <= 1'b0;
		end
		else
		begin
			ext_raw_q    <= external_count_pin_i;
			ext_raw_prev <= ext_raw_q;
		end
	end

	// switching between the paths may drop or add one edge
	wire ext_level = tcon.sync_disable ? ext_raw_q : sync_lvl[0];
	wire ext_rise  = tcon.sync_disable ? (ext_raw_q & ~ext_raw_prev)
		: sync_rise[0];

	// a low level must be seen before the first counted rising edge
	logic ext_armed;

	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
			ext_armed <= 1'b0;
		else if (!timer_on || wr_count)
			ext_armed <= 1'b0;
		else if (!ext_level)
			ext_armed <= 1'b1;
	end

	// internal time bases from the single system clock
	logic [1:0]  instr_div;
	logic [10:0] temp_div;

	wire instr_tick = (instr_div == 2'(gst_pkg::INSTR_DIV - 1));
	wire temp_tick  = (temp_div == 11'(gst_pkg::TEMP_OSC_CYCLES - 1));

	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			instr_div <= 2'h0;
			temp_div  <= 11'h000;
		end
		else
		begin
			instr_div <= instr_div + 2'h1;
			temp_div  <= temp_tick ? 11'h000 : temp_div + 11'h001;
		end
	end

	// count clock selection
	logic src_tick;

	always_comb
	begin
		case (tcon.clock_source_select)
			gst_pkg::GST_CS_TEMP:  src_tick = temp_tick;
			gst_pkg::GST_CS_EXT:   src_tick = ext_rise && ext_armed;
			gst_pkg::GST_CS_SYS:   src_tick = 1'b1;
			default:               src_tick = instr_tick;
		endcase
	end

	// timer0 wrap detector, a one-cycle high pulse
	logic [7:0] t0_prev;
	logic       t0_pulse;

	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			t0_prev  <= 8'h00;
			t0_pulse <= 1'b0;
		end
		else
		begin
			t0_prev  <= eight_bit_timer_count_i;
			t0_pulse <= (t0_prev == gst_pkg::T0_WRAP_FROM) &&
				(eight_bit_timer_count_i == gst_pkg::T0_WRAP_TO);
		end
	end

	// gate source and polarity
	logic gate_raw;

	always_comb
	begin
		case (gcon.gate_source_select)
			gst_pkg::GST_GS_CMP2:  gate_raw = sync_lvl[3];
			gst_pkg::GST_GS_CMP1:  gate_raw = sync_lvl[2];
			gst_pkg::GST_GS_T0:    gate_raw = t0_pulse;
			default:               gate_raw = sync_lvl[1];
		endcase
	end

	wire gate_act = gcon.gate_polarity ? gate_raw : ~gate_raw;

	// toggle flip-flop measures whole periods of the gate
	logic gate_act_prev;
	logic toggle_ff;

	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			gate_act_prev <= 1'b0;
			toggle_ff     <= 1'b0;
		end
		else
		begin
			gate_act_prev <= gate_act;
			if (!gcon.toggle_mode_enable || !timer_on)
				toggle_ff <= 1'b0;
			else if (gate_act && !gate_act_prev)
				toggle_ff <= ~toggle_ff;
		end
	end

	wire gate_mid = gcon.toggle_mode_enable ? toggle_ff : gate_act;
	logic gate_mid_prev;
	wire  gate_mid_rise = gate_mid & ~gate_mid_prev;

	// single pulse: wait for a leading edge, run until trailing edge
	wire sp_run = ((sp_state == gst_pkg::GST_SP_WAIT) && gate_mid_rise) ||
		((sp_state == gst_pkg::GST_SP_RUN) && gate_mid);
	wire go_write = wr_gcon && wr_data_i[3];

	always_comb
	begin
		next_sp_state = sp_state;
		case (sp_state)
			gst_pkg::GST_SP_WAIT:
				if (gate_mid_rise)
					next_sp_state = gst_pkg::GST_SP_RUN;
			gst_pkg::GST_SP_RUN:
				if (!gate_mid)
					next_sp_state = gst_pkg::GST_SP_IDLE;
			default:
				next_sp_state = gst_pkg::GST_SP_IDLE;
		endcase
		if (wr_gcon)
			next_sp_state = go_write ? gst_pkg::GST_SP_WAIT
				: gst_pkg::GST_SP_IDLE;
		if (wr_gcon ? !wr_data_i[4] : !gcon.single_pulse_enable)
			next_sp_state = gst_pkg::GST_SP_IDLE;
	end

	// gate value is live whether or not gating is enabled
	wire gate_value = gcon.single_pulse_enable ? sp_run : gate_mid;
	logic gate_value_prev;
	wire  gate_fall = gate_value_prev & ~gate_value;

	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			sp_state        <= gst_pkg::GST_SP_IDLE;
			gate_mid_prev   <= 1'b0;
			gate_value_prev <= 1'b0;
		end
		else
		begin
			sp_state        <= next_sp_state;
			gate_mid_prev   <= gate_mid;
			gate_value_prev <= gate_value;
		end
	end

	// count enable: on bit, gate, and sleep restriction
	wire sleep_ok = !sleep_i || async_ext;
	wire count_en = timer_on && (!gcon.gate_enable || gate_value)
		&& sleep_ok;
	logic inc;

	gst_prescaler #(
		.WIDTH (3)
	) u_prescaler (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.clear_i   (wr_count),
		.tick_i    (src_tick && count_en),
		.select_i  (tcon.prescale_select),
		.tick_o    (inc)
	);

	// software write replaces the byte and beats the increment
	always_comb
	begin
		next_count = count;
		if (wr_low)
			next_count = {count[15:8], wr_data_i};
		else if (wr_high)
			next_count = {wr_data_i, count[7:0]};
		else if (inc)
			next_count = count + 16'h0001;
	end

	wire rollover = inc && !wr_count && (count == gst_pkg::COUNT_MAX);

	// control registers; go and gate value are live, not stored
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			count   <= 16'h0000;
			tcon    <= gst_pkg::gst_timer_control_t'(gst_pkg::RESET_BYTE);
			gcon    <= gst_pkg::gst_gate_control_t'(gst_pkg::RESET_BYTE);
			irq_ctl <= gst_pkg::RESET_BYTE;
		end
		else
		begin
			count <= next_count;
			if (wr_tcon)
				tcon <= gst_pkg::gst_timer_control_t'(wr_data_i & 8'hF5);
			if (wr_gcon)
				gcon <= gst_pkg::gst_gate_control_t'(wr_data_i & 8'hF3);
			if (wr_irq)
				irq_ctl <= wr_data_i & 8'hE1;
		end
	end

	// sticky flags; a hardware set wins over a software clear
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			ovf_flag  <= 1'b0;
			gate_flag <= 1'b0;
		end
		else
		begin
			ovf_flag  <= rollover ||
				(wr_flags ? wr_data_i[gst_pkg::BIT_OVF_FLAG] : ovf_flag);
			gate_flag <= gate_fall ||
				(wr_flags ? wr_data_i[gst_pkg::BIT_GATE_FLAG] : gate_flag);
		end
	end

	// interrupt request and wake from sleep
	wire periph_ie = irq_ctl[gst_pkg::BIT_PERIPH_IE];
	wire global_ie = irq_ctl[gst_pkg::BIT_GLOBAL_IE];
	wire ovf_req   = ovf_flag && irq_ctl[gst_pkg::BIT_OVF_IE] && timer_on;
	wire gate_req  = gate_flag && irq_ctl[gst_pkg::BIT_GATE_IE];

	// wake needs no global enable; the cpu vectors only if it is set
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			irq_o  <= 1'b0;
			wake_o <= 1'b0;
		end
		else
		begin
			irq_o  <= (ovf_req || gate_req) && periph_ie && global_ie;
			wake_o <= sleep_i && async_ext && ovf_req && periph_ie;
		end
	end

	// read data selection
	logic [7:0] rd_next;

	always_comb
	begin
		if (addr_i == gst_pkg::OFF_COUNT_LOW)
			rd_next = count[7:0];
		else if (addr_i == gst_pkg::OFF_COUNT_HIGH)
			rd_next = count[15:8];
		else if (addr_i == gst_pkg::OFF_TIMER_CTL)
			rd_next = tcon;
		else if (addr_i == gst_pkg::OFF_GATE_CTL)
			rd_next = {gcon[7:4], sp_state != gst_pkg::GST_SP_IDLE,
				gate_value, gcon[1:0]};
		else if (addr_i == gst_pkg::OFF_FLAGS)
			rd_next = {gate_flag, 6'h00, ovf_flag};
		else if (addr_i == gst_pkg::OFF_IRQ_CTL)
			rd_next = irq_ctl;
		else
			rd_next = 8'h00;
	end

	// read data stands one cycle, zero otherwise; count mirrored out
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			rd_data_o <= 8'h00;
			count_o   <= 16'h0000;
		end
		else
		begin
			rd_data_o <= rd_i ? rd_next : 8'h00;
			count_o   <= next_count;
		end
	end
endmodule

// ==== gst_timer_properties.sv ====
/*
 * port checker of the gated sixteen-bit timer.
 * assumes one clock and the byte register map of the package.
 */
module gst_timer_properties (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  wr_data_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        sleep_i,
	input  wire logic [7:0]  rd_data_o,
	input  wire logic [15:0] count_o,
	input  wire logic        irq_o,
	input  wire logic        wake_o
);
	logic on_q;
	logic global_ie_q;
	wire  cnt_wr;
	// any write to either count byte
	assign cnt_wr = wr_i && addr_i[2:1] == 2'h0;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// shadow of the enables, so holds are tied to what software asked for
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i)
		begin
			on_q <= 1'b0;
			global_ie_q <= 1'b0;
		end
		else if (wr_i && addr_i == gst_pkg::OFF_TIMER_CTL)
			on_q <= wr_data_i[0];
		else if (wr_i && addr_i == gst_pkg::OFF_IRQ_CTL)
			global_ie_q <= wr_data_i[gst_pkg::BIT_GLOBAL_IE];
	end
	sequence s_low_wr;
		wr_i && addr_i == gst_pkg::OFF_COUNT_LOW;
	endsequence
	sequence s_high_wr;
		wr_i && addr_i == gst_pkg::OFF_COUNT_HIGH;
	endsequence
	a_low_write_wins: assert property (s_low_wr |=>
		count_o == {$past(count_o[15:8]), $past(wr_data_i)}) else $error("low byte write lost");
	a_high_write_wins: assert property (s_high_wr |=>
		count_o == {$past(wr_data_i), $past(count_o[7:0])}) else $error("high byte write lost");
	a_count_single_step: assert property (!cnt_wr |=>
		count_o == $past(count_o) || count_o == $past(count_o) + 16'h0001)
		else $error("count moved by more than one");
	a_off_holds_count: assert property (!on_q && !cnt_wr |=> $stable(count_o))
		else $error("count moved while stopped");
	a_read_low_count: assert property (rd_i && addr_i == gst_pkg::OFF_COUNT_LOW |=>
		rd_data_o == $past(count_o[7:0])) else $error("count read mismatch");
	a_idle_read_zero: assert property (!rd_i |=> rd_data_o == 8'h00)
		else $error("read data without read");
	a_irq_needs_global: assert property (!global_ie_q && !$past(global_ie_q) |-> !irq_o)
		else $error("interrupt without global enable");
	a_wake_needs_sleep: assert property (!sleep_i && !$past(sleep_i) |-> !wake_o)
		else $error("wake while awake");
endmodule

bind gst_timer gst_timer_properties chk_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
	.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .sleep_i(sleep_i),
	.rd_data_o(rd_data_o), .count_o(count_o), .irq_o(irq_o), .wake_o(wake_o));

// ==== gst_far_model.sv ====
/*
 * far side of the timer: external count clock and timer0 count.
 * assumes the bench drives the gate pin and comparator levels.
 */
module gst_far_model #(
	parameter int PERIOD = 8
) (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       ext_run_i,
	input  wire logic       t0_run_i,
	output logic            ext_pin_o,
	output logic [7:0]      t0_count_o
);
	int phase;
	// pin parks low when idle, so a low level always precedes the first rise
	always_ff @(posedge sys_clk_i)
	begin
		if (!reset_n_i || !ext_run_i)
			phase <= 0;
		else
			phase <= (phase + 1) % PERIOD;
		if (!reset_n_i)
			t0_count_o <= 8'h00;
		else if (t0_run_i)
			t0_count_o <= t0_count_o + 8'h01;
	end
	assign ext_pin_o = phase >= PERIOD / 2;
endmodule

// ==== tb_top.sv ====
/*
 * self-checking bench of the gated timer: clock modes, gate modes, flags.
 * assumes the far-side model for the count pin and timer0 count.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int EXT_PERIOD = 8;
	logic        sys_clk_i;
	logic        reset_n_i;
	logic [2:0]  addr_i;
	logic [7:0]  wr_data_i;
	logic        wr_i;
	logic        rd_i;
	logic        ext_pin;
	logic        gate_input;
	logic        cmp_one;
	logic        cmp_two;
	logic [7:0]  t0_count;
	logic        sleep_i;
	logic [7:0]  rd_data_o;
	logic [15:0] count_o;
	logic        irq_o;
	logic        wake_o;
	logic        ext_run;
	logic        t0_run;
	logic [7:0]  v;
	int          error_cnt = 0;
	int          checked = 0;
	int          cycles = 0;
	int          b;
	logic [7:0]  tcon_tab [9] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h01, 8'h31, 8'h81, 8'h95, 8'hC1};

	gst_timer dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .external_count_pin_i(ext_pin),
		.gate_input_i(gate_input), .comparator_one_out_i(cmp_one),
		.comparator_two_out_i(cmp_two), .eight_bit_timer_count_i(t0_count), .sleep_i(sleep_i),
		.rd_data_o(rd_data_o), .count_o(count_o), .irq_o(irq_o), .wake_o(wake_o));
	gst_far_model #(.PERIOD(EXT_PERIOD)) far_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.ext_run_i(ext_run), .t0_run_i(t0_run), .ext_pin_o(ext_pin), .t0_count_o(t0_count));

	initial
	begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	task automatic test_done();
		$display("checked %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			test_done();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 v = rd_data_o;
	endtask

	// settle past the synchroniser delay, then see whether the count moves
	task automatic moving(input logic exp, input int n);
		logic [15:0] c;
		repeat (6) @(posedge sys_clk_i);
		c = count_o;
		repeat (n) @(posedge sys_clk_i);
		chk(16'(count_o !== c), 16'(exp));
	endtask

	// first wait aligns on a step, second measures one full step
	task automatic gap(input int exp);
		logic [15:0] c;
		int n;
		repeat (2)
		begin
			c = count_o;
			n = 0;
			while (count_o === c && n < 3000)
			begin
				@(posedge sys_clk_i);
				n++;
			end
		end
		chk(16'(n), 16'(exp));
	endtask

	task automatic pulse();
		@(posedge sys_clk_i);
		gate_input <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		gate_input <= 1'b0;
	endtask

	initial
	begin
		reset_n_i = 1'b0;
		addr_i = 3'h0;
		wr_data_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		gate_input = 1'b0;
		cmp_one = 1'b0;
		cmp_two = 1'b0;
		sleep_i = 1'b0;
		ext_run = 1'b0;
		t0_run = 1'b0;
		repeat (5) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		// every index after reset, unmapped ones too; gate level bit masked
		for (int a = 0; a < 8; a++)
		begin
			rd(3'(a));
			chk(16'(v & 8'hFB), 16'h0000);
		end
		ext_run <= 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			wr(gst_pkg::OFF_TIMER_CTL, 8'h00);
			wr(gst_pkg::OFF_TIMER_CTL, tcon_tab[i]);
			b = tcon_tab[i][7:6] == 2'h1 ? 1 : tcon_tab[i][7:6] == 2'h0 ? gst_pkg::INSTR_DIV :
				tcon_tab[i][7:6] == 2'h2 ? EXT_PERIOD : gst_pkg::TEMP_OSC_CYCLES;
			gap(b << tcon_tab[i][5:4]);
		end
		// leave the prescaler part-way, then a count write must restart it
		wr(gst_pkg::OFF_TIMER_CTL, 8'h71);
		wr(gst_pkg::OFF_TIMER_CTL, 8'h70);
		wr(gst_pkg::OFF_COUNT_HIGH, 8'h00);
		wr(gst_pkg::OFF_COUNT_LOW, 8'h00);
		wr(gst_pkg::OFF_TIMER_CTL, 8'h71);
		repeat (8) @(posedge sys_clk_i);
		chk(count_o, 16'h0000);
		@(posedge sys_clk_i);
		chk(count_o, 16'h0001);
		// rollover in asynchronous mode while asleep
		wr(gst_pkg::OFF_TIMER_CTL, 8'h00);
		wr(gst_pkg::OFF_COUNT_LOW, 8'hFE);
		wr(gst_pkg::OFF_COUNT_HIGH, 8'hFF);
		wr(gst_pkg::OFF_IRQ_CTL, 8'h41);
		sleep_i <= 1'b1;
		wr(gst_pkg::OFF_TIMER_CTL, 8'h85);
		repeat (40) @(posedge sys_clk_i);
		chk(16'(wake_o), 16'h0001);
		chk(16'(irq_o), 16'h0000);
		rd(gst_pkg::OFF_FLAGS);
		chk(16'(v & 8'h01), 16'h0001);
		wr(gst_pkg::OFF_IRQ_CTL, 8'hC1);
		repeat (2) @(posedge sys_clk_i);
		chk(16'(irq_o), 16'h0001);
		wr(gst_pkg::OFF_FLAGS, 8'h00);
		repeat (2) @(posedge sys_clk_i);
		chk(16'(irq_o), 16'h0000);
		// synchronised counting must freeze while asleep
		wr(gst_pkg::OFF_TIMER_CTL, 8'h81);
		moving(1'b0, 20);
		sleep_i <= 1'b0;
		ext_run <= 1'b0;
		wr(gst_pkg::OFF_IRQ_CTL, 8'h00);
		wr(gst_pkg::OFF_TIMER_CTL, 8'h41);
		for (int p = 0; p < 2; p++)
		begin
			wr(gst_pkg::OFF_GATE_CTL, 8'h80 | 8'(p << 6));
			gate_input <= p[0];
			moving(1'b1, 10);
			gate_input <= ~p[0];
			moving(1'b0, 10);
		end
		rd(gst_pkg::OFF_FLAGS);
		chk(16'(v & 8'h80), 16'h0080);
		wr(gst_pkg::OFF_GATE_CTL, 8'h40);
		wr(gst_pkg::OFF_FLAGS, 8'h00);
		gate_input <= 1'b1;
		moving(1'b1, 10);
		rd(gst_pkg::OFF_GATE_CTL);
		chk(16'(v & 8'h04), 16'h0004);
		gate_input <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		rd(gst_pkg::OFF_FLAGS);
		chk(16'(v & 8'h80), 16'h0080);
		for (int s = 1; s < 4; s++)
		begin
			wr(gst_pkg::OFF_GATE_CTL, 8'hC0 | 8'(s));
			t0_run <= s == 1;
			cmp_one <= s == 2;
			cmp_two <= s == 3;
			moving(1'b1, s == 1 ? 300 : 10);
		end
		cmp_two <= 1'b0;
		cmp_one <= 1'b1;
		moving(1'b0, 10);
		cmp_one <= 1'b0;
		wr(gst_pkg::OFF_GATE_CTL, 8'hD8);
		rd(gst_pkg::OFF_GATE_CTL);
		chk(16'(v & 8'h08), 16'h0008);
		moving(1'b0, 10);
		gate_input <= 1'b1;
		moving(1'b1, 10);
		gate_input <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		rd(gst_pkg::OFF_GATE_CTL);
		chk(16'(v & 8'h08), 16'h0000);
		gate_input <= 1'b1;
		moving(1'b0, 10);
		gate_input <= 1'b0;
		wr(gst_pkg::OFF_GATE_CTL, 8'hD8);
		wr(gst_pkg::OFF_GATE_CTL, 8'hC8);
		rd(gst_pkg::OFF_GATE_CTL);
		chk(16'(v & 8'h08), 16'h0000);
		wr(gst_pkg::OFF_GATE_CTL, 8'hE0);
		pulse();
		moving(1'b1, 10);
		pulse();
		moving(1'b0, 10);
		wr(gst_pkg::OFF_GATE_CTL, 8'hF8);
		pulse();
		moving(1'b1, 10);
		pulse();
		moving(1'b0, 10);
		wr(gst_pkg::OFF_GATE_CTL, 8'hE0);
		pulse();
		wr(gst_pkg::OFF_GATE_CTL, 8'hC0);
		moving(1'b0, 10);
		// re-enabling toggle must start from a cleared flip-flop
		wr(gst_pkg::OFF_GATE_CTL, 8'hE0);
		moving(1'b0, 10);
		wr(gst_pkg::OFF_GATE_CTL, 8'h00);
		wr(gst_pkg::OFF_TIMER_CTL, 8'h40);
		moving(1'b0, 10);
		test_done();
	end
endmodule
